// ### verilog/fpra_accum.sv
// Range-limited floating-point accumulator with AHB-Lite status registers
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module fpra_accum #(
	parameter bit DOUBLE           = 1'b0,
	parameter int INPUT_TOP_WEIGHT = fpra_pkg::DEF_INPUT_TOP_WEIGHT,
	parameter int SUM_TOP_WEIGHT   = fpra_pkg::DEF_SUM_TOP_WEIGHT,
	parameter int SUM_LOW_WEIGHT   = fpra_pkg::DEF_SUM_LOW_WEIGHT,
	parameter int TARGET_MHZ       = fpra_pkg::DEF_TARGET_MHZ,
	parameter bit HAS_GATE         = 1'b0
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        accum_gate,
	input  wire logic [63:0] in_value,
	input  wire logic        set_start,
	output logic      [63:0] total_out,
	output logic             input_ovf_flag,
	output logic             input_small_flag,
	output logic             sum_ovf_flag,
	output logic      [7:0]  latency_out,
	output logic             irq,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata
);

	// ==========================================================
	// Derived sizes
	// Sign bit directly above the top weight, no guard bit
	localparam int AW    = SUM_TOP_WEIGHT - SUM_LOW_WEIGHT + 2;
	localparam int WIDE  = AW + fpra_pkg::FRAC_W + 1;
	localparam int EXTRA = (TARGET_MHZ > fpra_pkg::MHZ_TWO_EXTRA) ? 2 :
		(TARGET_MHZ > fpra_pkg::MHZ_ONE_EXTRA) ? 1 : 0;
	localparam int LATENCY = fpra_pkg::BASE_LATENCY + EXTRA;
	localparam int BIAS = DOUBLE ? fpra_pkg::BIAS_DOUBLE :
		fpra_pkg::BIAS_SINGLE;

	// ==========================================================
	// State
	typedef struct packed {
		logic          start;
		logic          xo;
		logic          xu;
		logic [AW-1:0] val;
	} fpra_in_t;

	typedef struct packed {
		logic          start;
		logic          xo;
		logic          xu;
		logic          ao;
		logic [AW-1:0] acc;
	} fpra_acc_t;

	typedef struct packed {
		logic        start;
		logic        xo;
		logic        xu;
		logic        ao;
		logic [63:0] total;
	} fpra_out_t;

	typedef struct packed {
		fpra_in_t              s1;
		fpra_acc_t             sa;
		fpra_out_t [EXTRA:0]   pipe;
		logic      [2:0]       status;
		logic      [2:0]       mask;
		logic                  irq;
		logic                  wr_pend;
		logic      [7:0]       addr_q;
		logic      [31:0]      rdata;
		logic                  ready;
		logic      [7:0]       lat;
	} fpra_state_t;

	fpra_state_t st;
	fpra_state_t next_st;

	logic            run;
	logic [10:0]     exp_field;
	logic            exp_ones;
	logic [51:0]     frac;
	logic            in_sign;
	int              in_exp;
	int              shift;
	logic [WIDE-1:0] ext;
	logic [AW-1:0]   aligned;
	logic [AW:0]     sum_w;
	logic [AW-1:0]   mag;
	int              lead;
	logic [WIDE-2:0] norm;
	logic [10:0]     out_exp;
	fpra_out_t       conv;
	logic [2:0]      new_flags;
	logic [2:0]      old_flags;
	logic [2:0]      events;
	logic [2:0]      clr;
	logic            take;

	// Without the gate option everything runs on every clock
	assign run = !HAS_GATE || accum_gate;

	always_comb
	begin
		next_st   = st;
		exp_field = 11'h000;
		exp_ones  = 1'b0;
		frac      = 52'h0_0000_0000_0000;
		in_sign   = 1'b0;
		in_exp    = 0;
		shift     = 0;
		ext       = '0;
		aligned   = '0;
		sum_w     = '0;
		mag       = '0;
		lead      = 0;
		norm      = '0;
		out_exp   = 11'h000;
		conv      = '0;
		new_flags = 3'h0;
		old_flags = 3'h0;
		events    = 3'h0;
		clr       = 3'h0;
		take      = 1'b0;

		// ======================================================
		// Stage 1: unpack and align to the fixed-point grid
		if (DOUBLE)
		begin
			in_sign   = in_value[63];
			exp_field = in_value[62:52];
			exp_ones  = &in_value[62:52];
			frac      = in_value[51:0];
		end
		else
		begin
			in_sign   = in_value[31];
			exp_field = {3'h0, in_value[30:23]};
			exp_ones  = &in_value[30:23];
			frac      = {in_value[22:0], 29'h0};
		end
		in_exp = int'(exp_field) - BIAS;
		shift  = in_exp - fpra_pkg::FRAC_W - SUM_LOW_WEIGHT;
		ext    = WIDE'({1'b1, frac});
		if (shift >= 0)
			ext = ext << shift;
		else
			ext = ext >> (-shift);
		aligned = ext[AW-1:0];
		// Zero and denormal inputs count as zero; overflowing ones add
		// nothing since the flag already spoils the sum
		if (exp_field == 11'h000 || exp_ones || in_exp > INPUT_TOP_WEIGHT)
			aligned = '0;
		if (in_sign)
			aligned = AW'(~aligned + 1'b1);

		if (run)
		begin
			next_st.s1.start = set_start;
			next_st.s1.val   = aligned;
			next_st.s1.xo    = exp_ones ||
				(exp_field != 11'h000 && in_exp > INPUT_TOP_WEIGHT);
			next_st.s1.xu    = (exp_field == 11'h000 && frac != 52'h0) ||
				(exp_field != 11'h000 && in_exp < SUM_LOW_WEIGHT);
		end

		// ======================================================
		// Stage 2: accumulate, restarting on a new set
		sum_w = {st.sa.acc[AW-1], st.sa.acc} + {st.s1.val[AW-1], st.s1.val};
		if (run)
		begin
			next_st.sa.start = st.s1.start;
			if (st.s1.start)
			begin
				next_st.sa.acc = st.s1.val;
				next_st.sa.xo  = st.s1.xo;
				next_st.sa.xu  = st.s1.xu;
				next_st.sa.ao  = 1'b0;
			end
			else
			begin
				next_st.sa.acc = sum_w[AW-1:0];
				next_st.sa.xo  = st.sa.xo | st.s1.xo;
				next_st.sa.xu  = st.sa.xu | st.s1.xu;
				next_st.sa.ao  = st.sa.ao | (sum_w[AW] ^ sum_w[AW-1]);
			end
		end

		// ======================================================
		// Stage 3: back to floating point, truncating spare bits
		mag = st.sa.acc[AW-1] ? AW'(~st.sa.acc + 1'b1) : st.sa.acc;
		for (int i = 0; i < AW; i++)
			if (mag[i])
				lead = i;
		norm    = (WIDE-1)'({mag, 52'h0}) << (AW - 1 - lead);
		out_exp = 11'(lead + SUM_LOW_WEIGHT + BIAS);
		conv.start = st.sa.start;
		conv.xo    = st.sa.xo;
		conv.xu    = st.sa.xu;
		conv.ao    = st.sa.ao;
		if (mag == '0)
			conv.total = 64'h0000_0000_0000_0000;
		else if (DOUBLE)
			conv.total = {st.sa.acc[AW-1], out_exp, norm[AW+50:AW-1]};
		else
			conv.total = {32'h0000_0000, st.sa.acc[AW-1], out_exp[7:0],
				norm[AW+50:AW+28]};

		// Extra stages bought for clock rate; the last one drives the pins
		if (run)
		begin
			next_st.pipe[0] = conv;
			for (int j = 1; j <= EXTRA; j++)
				next_st.pipe[j] = st.pipe[j-1];
		end

		// ======================================================
		// Interrupt status: rise of an output flag is an event
		new_flags = {next_st.pipe[EXTRA].ao, next_st.pipe[EXTRA].xu,
			next_st.pipe[EXTRA].xo};
		old_flags = {st.pipe[EXTRA].ao, st.pipe[EXTRA].xu,
			st.pipe[EXTRA].xo};
		if (run)
			events = new_flags & (~old_flags | {3{next_st.pipe[EXTRA].start}});

		// ======================================================
		// AHB-Lite slave: zero wait states, always OKAY
		if (st.wr_pend)
		begin
			if (st.addr_q == fpra_pkg::OFF_STATUS)
				clr = hwdata[2:0];
			if (st.addr_q == fpra_pkg::OFF_MASK)
				next_st.mask = hwdata[2:0];
		end
		// Set beats clear so no event is lost
		next_st.status = (st.status & ~clr) | events;
		next_st.irq    = |(next_st.status & next_st.mask);

		take = hsel && htrans[1] && hready;
		next_st.wr_pend = take && hwrite;
		if (take)
			next_st.addr_q = haddr[7:0];
		if (take && !hwrite)
		begin
			unique case (haddr[7:0])
				fpra_pkg::OFF_STATUS:  next_st.rdata = {29'h0, st.status};
				fpra_pkg::OFF_MASK:    next_st.rdata = {29'h0, st.mask};
				fpra_pkg::OFF_FLAGS:   next_st.rdata = {29'h0, old_flags};
				fpra_pkg::OFF_LATENCY: next_st.rdata = {24'h00_0000, st.lat};
				default:               next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			st        <= '0;
			st.status <= fpra_pkg::RST_STATUS;
			st.mask   <= fpra_pkg::RST_MASK;
			st.ready  <= 1'b1;
			st.lat    <= 8'(LATENCY);
		end
		else
			st <= next_st;
	end

	assign total_out        = st.pipe[EXTRA].total;
	assign input_ovf_flag   = st.pipe[EXTRA].xo;
	assign input_small_flag = st.pipe[EXTRA].xu;
	assign sum_ovf_flag     = st.pipe[EXTRA].ao;
	assign latency_out      = st.lat;
	assign irq              = st.irq;
	assign hreadyout        = st.ready;
	assign hresp            = 1'b0;
	assign hrdata           = st.rdata;

	// ==========================================================
	// Checks
	localparam int LAT_A  = LATENCY;
	localparam int LAT_M1 = LATENCY - 1;

	logic out_start;
	logic gate_built;
	assign out_start  = st.pipe[EXTRA].start;
	assign gate_built = HAS_GATE;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset || gate_built);

	a_ovf_latency: assert property (set_start && !DOUBLE && &in_value[30:23]
		|-> ##LAT_A input_ovf_flag && !sum_ovf_flag)
		else $error("input overflow flag not raised after latency");

	a_small_latency: assert property (set_start && !DOUBLE
		&& in_value[30:23] == 8'h01
		|-> ##LAT_A input_small_flag && !input_ovf_flag)
		else $error("input small flag not raised after latency");

	a_start_clears: assert property (set_start && in_value == 64'h0
		|-> ##LAT_A total_out == 64'h0 && !input_ovf_flag
		&& !input_small_flag && !sum_ovf_flag)
		else $error("new set did not restart sum and flags");

	a_running_sum: assert property ((set_start && !DOUBLE
		&& in_value == {32'h0, fpra_pkg::FP_ONE_SINGLE})
		##1 (!set_start && in_value == {32'h0, fpra_pkg::FP_ONE_SINGLE})
		|-> ##LAT_M1 total_out[31:0] == fpra_pkg::FP_ONE_SINGLE
		##1 total_out[31:0] == fpra_pkg::FP_TWO_SINGLE)
		else $error("running sum wrong");

	a_flags_sticky: assert property ($fell(input_ovf_flag)
		|| $fell(input_small_flag) || $fell(sum_ovf_flag)
		|-> out_start)
		else $error("sticky flag dropped inside a set");

	a_single_upper: assert property (!DOUBLE |-> total_out[63:32] == 32'h0
		|| 1'b0)
		else $error("single result has upper bits set");

	a_latency_read: assert property (hsel && htrans[1] && hready && !hwrite
		&& haddr[7:0] == fpra_pkg::OFF_LATENCY
		|=> hrdata == 32'(LATENCY) && latency_out == 8'(LATENCY))
		else $error("latency register wrong");

	a_irq_event: assert property ($rose(input_ovf_flag)
		&& st.mask[fpra_pkg::BIT_INPUT_OVF] |-> irq ##1 irq)
		else $error("interrupt not raised on masked event");

	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("slave not ready or error response");

	a_gate_hold: assert property (@(posedge ref_clk) disable iff (reset)
		HAS_GATE && !accum_gate |=> $stable(total_out)
		&& $stable(input_ovf_flag) && $stable(sum_ovf_flag))
		else $error("outputs moved while gate low");

	c_new_set:   cover property (set_start ##LAT_A out_start);
	c_input_ovf: cover property ($rose(input_ovf_flag));
	c_sum_ovf:   cover property ($rose(sum_ovf_flag));
	c_irq:       cover property ($rose(irq));

endmodule

`default_nettype wire

// ### verilog/fpra_pkg.sv
// Constants shared by the range-limited floating-point accumulator
package fpra_pkg;

	// ==========================================================
	// Number formats
	localparam int FRAC_W        = 52;
	localparam int BIAS_SINGLE   = 127;
	localparam int BIAS_DOUBLE   = 1023;
	localparam logic [31:0] FP_ONE_SINGLE = 32'h3F80_0000;
	localparam logic [31:0] FP_TWO_SINGLE = 32'h4000_0000;

	// ==========================================================
	// Default ranges and build options
	localparam int DEF_INPUT_TOP_WEIGHT = 12;
	localparam int DEF_SUM_TOP_WEIGHT   = 20;
	localparam int DEF_SUM_LOW_WEIGHT   = -26;
	localparam int DEF_TARGET_MHZ       = 200;

	// ==========================================================
	// Pipeline depth against target frequency
	localparam int BASE_LATENCY   = 3;
	localparam int MHZ_ONE_EXTRA  = 150;
	localparam int MHZ_TWO_EXTRA  = 300;

	// ==========================================================
	// Register map (byte offsets within the slave)
	localparam logic [7:0] OFF_STATUS  = 8'h00;
	localparam logic [7:0] OFF_MASK    = 8'h04;
	localparam logic [7:0] OFF_FLAGS   = 8'h08;
	localparam logic [7:0] OFF_LATENCY = 8'h0C;

	// Event bit positions in status, mask and flags registers
	localparam int BIT_INPUT_OVF   = 0;
	localparam int BIT_INPUT_SMALL = 1;
	localparam int BIT_SUM_OVF     = 2;

	// Reset values
	localparam logic [2:0] RST_STATUS = 3'h0;
	localparam logic [2:0] RST_MASK   = 3'h0;

endpackage

// ### testbench/fpra_src.sv
// Sample source standing in for the user datapath ahead of the accumulator
`timescale 1ns/1ps
`default_nettype none

module fpra_src (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [63:0] req_value,
	input  wire logic        req_first,
	output logic      [63:0] in_value,
	output logic             set_start
);
	// ==========================================================
	// Registered so samples and markers move only after ref_clk
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			in_value <= 64'h0;
			set_start <= 1'b0;
		end
		else
		begin
			in_value <= req_value;
			set_start <= req_first;
		end
	end
endmodule

`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the range-limited accumulator
`timescale 1ns/1ps
`default_nettype none

module tb;
	// ==========================================================
	// Sample table: marker, input, expected sum and flags
	typedef struct packed {logic st; logic [31:0] v; logic [31:0] t;
		logic tv; logic io; logic is;} fpra_row_t;
	localparam int LAT = 4;
	localparam int N = 16;
	fpra_row_t rows [N] = '{
		'{1'b1,32'h3F80_0000,32'h3F80_0000,1'b1,1'b0,1'b0},
		'{1'b0,32'h3F80_0000,32'h4000_0000,1'b1,1'b0,1'b0},
		'{1'b0,32'h4000_0000,32'h4080_0000,1'b1,1'b0,1'b0},
		'{1'b1,32'h4040_0000,32'h4040_0000,1'b1,1'b0,1'b0},
		'{1'b0,32'h3080_0000,32'h4040_0000,1'b1,1'b0,1'b1},
		'{1'b0,32'h3F80_0000,32'h4080_0000,1'b1,1'b0,1'b1},
		'{1'b1,32'h7F80_0000,32'h0000_0000,1'b0,1'b1,1'b0},
		'{1'b0,32'h3F80_0000,32'h0000_0000,1'b0,1'b1,1'b0},
		'{1'b1,32'h7FC0_0000,32'h0000_0000,1'b0,1'b1,1'b0},
		'{1'b1,32'h4600_0000,32'h0000_0000,1'b0,1'b1,1'b0},
		'{1'b1,32'h4580_0000,32'h4580_0000,1'b1,1'b0,1'b0},
		'{1'b0,32'h3280_0000,32'h4580_0000,1'b1,1'b0,1'b0},
		'{1'b0,32'h3000_0000,32'h4580_0000,1'b1,1'b0,1'b1},
		'{1'b0,32'hC580_0000,32'h3280_0000,1'b1,1'b0,1'b1},
		'{1'b1,32'h0080_0000,32'h0000_0000,1'b1,1'b0,1'b1},
		'{1'b1,32'h0000_0000,32'h0000_0000,1'b1,1'b0,1'b0}};

	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [63:0] src_v = 64'h0;
	logic        src_st = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] q;
	int          err_count = 0;
	int          total_checks = 0;
	int          cyc = 0;
	wire logic [63:0] in_value;
	wire logic        set_start;
	wire logic [63:0] total_out;
	wire logic        input_ovf_flag;
	wire logic        input_small_flag;
	wire logic        sum_ovf_flag;
	wire logic [7:0]  latency_out;
	wire logic        irq;
	wire logic        hreadyout;
	wire logic        hresp;
	wire logic [31:0] hrdata;

	fpra_src src_u (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.req_value (src_v),
		.req_first (src_st),
		.in_value  (in_value),
		.set_start (set_start)
	);

	// Gate held low: without the gate option it must be ignored
	fpra_accum dut_u (
		.ref_clk(ref_clk), .reset(reset), .accum_gate(1'b0),
		.in_value(in_value), .set_start(set_start),
		.total_out(total_out), .input_ovf_flag(input_ovf_flag),
		.input_small_flag(input_small_flag),
		.sum_ovf_flag(sum_ovf_flag), .latency_out(latency_out),
		.irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata)
	);

	always #25 ref_clk = ~ref_clk;

	task final_report;
		$display("Checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			err_count++;
			final_report();
		end
	end

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH at %0t got %h expected %h", $time, g, e);
		end
	endtask

	// One single AHB-Lite transfer; read data lands in q
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk(64'(hresp), 64'h0);
	endtask

	task automatic check_row(input fpra_row_t r);
		if (r.tv)
			chk(total_out, {32'h0000_0000, r.t});
		chk(64'(input_ovf_flag), 64'(r.io));
		chk(64'(input_small_flag), 64'(r.is));
		chk(64'(sum_ovf_flag), 64'h0);
	endtask

	initial
	begin
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		#1;
		chk(total_out, 64'h0);
		chk(64'({input_ovf_flag, input_small_flag, sum_ovf_flag, irq}), 64'h0);
		chk(64'(latency_out), 64'h4);
		// ======================================================
		// Table loop; the source register adds one edge to LAT
		for (int j = 0; j < N + LAT + 1; j++)
		begin
			@(posedge ref_clk);
			src_v <= (j < N) ? {32'h0000_0000, rows[j % N].v} : 64'h0;
			src_st <= (j < N) ? rows[j % N].st : 1'b0;
			#1;
			if (j >= LAT + 1)
				check_row(rows[j - LAT - 1]);
		end
		// ======================================================
		// Accumulator limit: 511 x 4096 fits, 512 x 4096 does not
		for (int j = 0; j < 518; j++)
		begin
			@(posedge ref_clk);
			src_v <= (j < 512) ? 64'h0000_0000_4580_0000 : 64'h0;
			src_st <= (j == 0);
			#1;
			if (j == 515)
			begin
				chk(total_out, 64'h0000_0000_49FF_8000);
				chk(64'(sum_ovf_flag), 64'h0);
			end
			if (j == 516)
				chk(64'(sum_ovf_flag), 64'h1);
		end
		// ======================================================
		// Status, mask and interrupt
		bus(1'b0, fpra_pkg::OFF_STATUS, 32'h0);
		chk(64'(q), 64'h7);
		chk(64'(irq), 64'h0);
		bus(1'b1, fpra_pkg::OFF_MASK, 32'h0000_0004);
		@(posedge ref_clk);
		#1;
		chk(64'(irq), 64'h1);
		bus(1'b1, fpra_pkg::OFF_STATUS, 32'h0000_0004);
		@(posedge ref_clk);
		#1;
		chk(64'(irq), 64'h0);
		bus(1'b0, fpra_pkg::OFF_STATUS, 32'h0);
		chk(64'(q), 64'h3);
		bus(1'b0, fpra_pkg::OFF_FLAGS, 32'h0);
		chk(64'(q), 64'h4);
		bus(1'b1, fpra_pkg::OFF_LATENCY, 32'h0);
		bus(1'b0, fpra_pkg::OFF_LATENCY, 32'h0);
		chk(64'(q), 64'h4);
		bus(1'b0, 8'h10, 32'h0);
		chk(64'(q), 64'h0);
		final_report();
	end
endmodule

`default_nettype wire
